// >>> src/disk_adapter_pkg.sv
// constants, register map and carrier types for the disk adapter control block
package disk_adapter_pkg;

    // register byte offsets on the apb slave
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_MAINT  = 8'h08;
    localparam logic [7:0] OFF_ECC    = 8'h0C;
    localparam logic [7:0] OFF_ERR1   = 8'h10;
    localparam logic [7:0] OFF_ERR2   = 8'h14;

    // control register fields
    localparam int CTRL_DRV_CLR = 0;   // write one: drive clear command
    localparam int CTRL_PORT_B  = 1;   // software port select, 1 = second port
    localparam int CTRL_DUAL    = 2;   // second-port transceivers fitted
    localparam int CTRL_SEARCH  = 3;   // search-enable latch
    localparam int CTRL_ON      = 4;   // on-latch

    // status register fields
    localparam int STAT_ATTN    = 0;   // attention flag, write one to clear
    localparam int STAT_STATE   = 1;   // two bits of sequencer state
    localparam int STAT_READY   = 3;
    localparam int STAT_PLUG    = 4;
    localparam int STAT_FAULT   = 5;
    localparam int STAT_PORT_B  = 6;

    localparam int REG_W        = 16;
    localparam int SYNC_W       = 30;

    // reset values
    localparam logic [15:0] MAINT_RST = 16'h0000;
    localparam logic [15:0] ECC_RST   = 16'h0000;
    localparam logic [15:0] ERR_RST   = 16'h0000;
    localparam logic [4:0]  CTRL_RST  = 5'h10;   // on-latch set, rest clear

    typedef enum logic [1:0] {st_off, st_start, st_run, st_fail} seq_state_t;

    // one controller port as seen through its transceivers
    typedef struct packed {
        logic       demand;
        logic       init;
        logic [2:0] drive_select_lines;
        logic [4:0] reg_sel;
    } port_bus_t;

    // power sequence inputs from the chain and the drive
    typedef struct packed {
        logic start_req;
        logic dc_ok;
        logic grant_in_n;
        logic start_busy_line;
        logic unit_ready;
        logic drive_fault;
    } seq_in_t;

    // power sequence outputs
    typedef struct packed {
        logic power_pick;
        logic power_hold;
        logic grant_out_n;
        logic busy_out;
        logic busy_oe_n;
    } seq_out_t;

    typedef struct packed {
        logic       present;
        logic [2:0] unit_plug_address;
    } unit_plug_t;

    localparam seq_out_t SEQ_OUT_RST = 5'h1D;   // pick, hold, no grant, released

endpackage

// >>> src/disk_adapter_ctrl.sv
// power sequencing, initialize/clear and drive selection for the disk adapter
//
// The address map and register access over APB were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - start only with start request, dc good, permit low and busy line high
// - hold off while another drive keeps the start-busy line low
// - on start negate pick and hold, pull start-busy line low
// - while starting watch ready; on ready pass permit on, release busy
// - failed start still passes permit until fault clears, then restart
// - switched off: pick and hold asserted, permit still passed along
// - after a stop, restart normally when start request returns
// - stopped drive passes incoming permit through unchanged
// - first drive in chain sees incoming permit tied low
// - initialize from either port clears attention and makes clear pulse
// - clear pulse resets maintenance bit 0, latches, ecc and error registers
// - power good at power-on and drive clear command also make clear pulse
// - compare three-bit drive select with three-bit unit plug address
// - one comparator per port, use the one of the selected port
// - comparators match only while the unit plug is present
// - on match start register handshake and enable register selection
// - route five register select lines of selected port onward
// - second port active only while fitted, selected only in second-port mode, same function as first
module disk_adapter_ctrl (
    input  wire logic                          pclk,             // 10 mhz system clock
    input  wire logic                          presetn,          // async reset, low
    input  wire logic [7:0]                    paddr,            // apb address
    input  wire logic                          psel,             // apb select
    input  wire logic                          penable,          // apb access phase
    input  wire logic                          pwrite,           // apb direction
    input  wire logic [31:0]                   pwdata,           // apb write data
    output logic      [31:0]                   prdata,           // apb read data
    output logic                               pready,           // apb ready
    output logic                               pslverr,          // unmapped address
    input  wire disk_adapter_pkg::port_bus_t   port_a,           // first port pins
    input  wire disk_adapter_pkg::port_bus_t   port_b,           // second port pins
    input  wire disk_adapter_pkg::seq_in_t     seq_in,           // chain and drive pins
    input  wire disk_adapter_pkg::unit_plug_t  unit_plug,        // front-panel plug
    input  wire logic                          attn_event,       // attention set pulse
    input  wire logic [15:0]                   err1_set,         // error one set bits
    input  wire logic [15:0]                   err2_set,         // error two set bits
    output disk_adapter_pkg::seq_out_t         seq_out,          // power chain outputs
    output logic                               adapter_clear_pulse, // one-cycle clear
    output logic                               drive_fault_clear,   // to drive init
    output logic                               handshake_start,  // selected and demanded
    output logic      [4:0]                    reg_select_out,   // routed register select
    output logic                               attention_flag,   // attention bit
    output logic                               search_enable,    // search-enable latch
    output logic                               on_latch          // on-latch
);
    import disk_adapter_pkg::*;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic [SYNC_W-1:0] s1_q;
    logic [SYNC_W-1:0] s2_q;
    logic [SYNC_W-1:0] s3_q;
    logic [SYNC_W-1:0] flt_q;
    logic [SYNC_W-1:0] flt_d;
    port_bus_t         pa_f;
    port_bus_t         pb_f;
    port_bus_t         sel_bus;
    seq_in_t           sq_f;
    unit_plug_t        plug_f;
    seq_state_t        state_q;
    seq_state_t        state_d;
    seq_out_t          seq_out_q;
    seq_out_t          seq_out_d;
    logic [4:0]        ctrl_q;
    logic [4:0]        ctrl_d;
    logic [15:0]       maint_q;
    logic [15:0]       ecc_q;
    logic [15:0]       err1_q;
    logic [15:0]       err2_q;
    logic              attn_q;
    logic              clear_q;
    logic              clear_src;
    logic [2:0]        prev_q;
    logic              init_rise;
    logic              pok_rise;
    logic              start_ok;
    logic              port_b_mode;
    logic              match_a;
    logic              match_b;
    logic              match;
    logic              hs_q;
    logic [4:0]        rsel_q;
    logic              wr_en;
    logic              setup;
    logic              hit;
    logic [31:0]       rdata_d;
    logic [31:0]       prdata_q;
    logic              slverr_d;
    logic              slverr_q;
    logic              wr_ctrl;
    logic              wr_stat;
    logic              wr_maint;
    logic              wr_ecc;
    logic              drv_clr_cmd;

    // comparator function, instanced once for each port
    function automatic logic addr_match(input logic [2:0] sel, input unit_plug_t plug);
        return plug.present && (sel == plug.unit_plug_address);
    endfunction

    // three-stage synchroniser; a bit changes once stages two and three agree
    assign flt_d = (s2_q & s3_q) | (flt_q & (s2_q | s3_q));
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            flt_q <= '0;
        end else begin
            s1_q  <= {port_a, port_b, seq_in, unit_plug};
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            flt_q <= flt_d;
        end
    end
    assign {pa_f, pb_f, sq_f, plug_f} = flt_q;

    // start gate; the first drive has its permit input strapped low
    assign start_ok = sq_f.start_req & sq_f.dc_ok
                    & ~sq_f.grant_in_n
                    & sq_f.start_busy_line;

    // power sequencer; a stop or lost dc during start or run falls back to the idle pass state
    always_comb begin
        state_d = state_q;
        case (state_q)
            st_off: begin
                if (start_ok) state_d = st_start;
            end
            st_start: begin
                if (!sq_f.start_req || !sq_f.dc_ok) state_d = st_off;
                else if (sq_f.drive_fault) state_d = st_fail;
                else if (sq_f.unit_ready) state_d = st_run;
            end
            st_run: begin
                if (!sq_f.start_req || !sq_f.dc_ok) state_d = st_off;
            end
            st_fail: begin
                if (!sq_f.drive_fault) state_d = st_off;
            end
            default: state_d = st_off;
        endcase
    end

    // chain outputs per state; busy line is open drain, only ever pulled low
    always_comb begin
        seq_out_d = SEQ_OUT_RST;
        case (state_q)
            st_off: begin
                seq_out_d.grant_out_n = sq_f.grant_in_n;
            end
            st_start: begin
                seq_out_d.power_pick = 1'h0;
                seq_out_d.power_hold = 1'h0;
                seq_out_d.busy_oe_n  = 1'h0;
            end
            st_run: begin
                seq_out_d.power_pick  = 1'h0;
                seq_out_d.power_hold  = 1'h0;
                seq_out_d.grant_out_n = 1'h0;
            end
            st_fail: begin
                seq_out_d.grant_out_n = 1'h0;
            end
            default: seq_out_d = SEQ_OUT_RST;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q   <= st_off;
            seq_out_q <= SEQ_OUT_RST;
        end else begin
            state_q   <= state_d;
            seq_out_q <= seq_out_d;
        end
    end
    assign seq_out = seq_out_q;

    // clear sources: initialize edges, power good edge, drive clear command
    assign port_b_mode = ctrl_q[CTRL_DUAL] & ctrl_q[CTRL_PORT_B];
    assign init_rise   = (pa_f.init & ~prev_q[0])
                       | (ctrl_q[CTRL_DUAL] & pb_f.init & ~prev_q[1]);
    assign pok_rise    = sq_f.dc_ok & ~prev_q[2];
    assign clear_src   = init_rise | pok_rise | drv_clr_cmd;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_q  <= 3'h0;
            clear_q <= 1'h0;
        end else begin
            prev_q  <= {sq_f.dc_ok, pb_f.init, pa_f.init};
            clear_q <= clear_src;
        end
    end
    assign adapter_clear_pulse = clear_q;
    assign drive_fault_clear   = clear_q;   // drive drops only faults whose cause is gone

    // selection: one comparator per port, the selected port's result is used
    assign match_a = addr_match(pa_f.drive_select_lines, plug_f);
    assign match_b = addr_match(pb_f.drive_select_lines, plug_f);
    assign match   = port_b_mode ? match_b : match_a;
    assign sel_bus = port_b_mode ? pb_f : pa_f;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hs_q   <= 1'h0;
            rsel_q <= 5'h00;
        end else begin
            hs_q   <= match & sel_bus.demand;
            rsel_q <= match ? sel_bus.reg_sel : 5'h00;
        end
    end
    assign handshake_start = hs_q;
    assign reg_select_out  = rsel_q;

    // apb decode; zero wait states, read data captured in the setup cycle
    assign setup    = psel & ~penable;
    assign wr_en    = psel & penable & pwrite;
    assign wr_ctrl  = wr_en & (paddr == OFF_CTRL);
    assign wr_stat  = wr_en & (paddr == OFF_STATUS);
    assign wr_maint = wr_en & (paddr == OFF_MAINT);
    assign wr_ecc   = wr_en & (paddr == OFF_ECC);
    assign drv_clr_cmd = wr_ctrl & pwdata[CTRL_DRV_CLR];

    always_comb begin
        rdata_d = 32'h0000_0000;
        hit     = 1'h1;
        if (paddr == OFF_CTRL) begin
            rdata_d[4:0] = {ctrl_q[4:1], 1'h0};
        end else if (paddr == OFF_STATUS) begin
            rdata_d[STAT_ATTN]            = attn_q;
            rdata_d[STAT_STATE +: 2]      = state_q;
            rdata_d[STAT_READY]           = sq_f.unit_ready;
            rdata_d[STAT_PLUG]            = plug_f.present;
            rdata_d[STAT_FAULT]           = sq_f.drive_fault;
            rdata_d[STAT_PORT_B]          = port_b_mode;
        end else if (paddr == OFF_MAINT) begin
            rdata_d[REG_W-1:0] = maint_q;
        end else if (paddr == OFF_ECC) begin
            rdata_d[REG_W-1:0] = ecc_q;
        end else if (paddr == OFF_ERR1) begin
            rdata_d[REG_W-1:0] = err1_q;
        end else if (paddr == OFF_ERR2) begin
            rdata_d[REG_W-1:0] = err2_q;
        end else begin
            hit = 1'h0;
        end
        slverr_d = ~hit;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
            slverr_q <= 1'h0;
        end else if (setup) begin
            prdata_q <= pwrite ? 32'h0000_0000 : rdata_d;
            slverr_q <= slverr_d;
        end
    end
    assign prdata  = prdata_q;
    assign pready  = 1'h1;
    assign pslverr = psel & penable & slverr_q;

    // control latches; the clear pulse overrides a same-cycle software write of the on and search latches
    always_comb begin
        ctrl_d = ctrl_q;
        if (wr_ctrl) ctrl_d = {pwdata[4:1], 1'h0};
        if (clear_q) begin
            ctrl_d[CTRL_ON]     = 1'h1;
            ctrl_d[CTRL_SEARCH] = 1'h0;
        end
    end

    // registers that the clear pulse resets; hardware error sets beat the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q  <= CTRL_RST;
            maint_q <= MAINT_RST;
            ecc_q   <= ECC_RST;
            err1_q  <= ERR_RST;
            err2_q  <= ERR_RST;
            attn_q  <= 1'h0;
        end else begin
            ctrl_q <= ctrl_d;
            if (clear_q) maint_q <= {maint_q[15:1], 1'h0};
            else if (wr_maint) maint_q <= pwdata[15:0];
            if (clear_q) ecc_q <= ECC_RST;
            else if (wr_ecc) ecc_q <= pwdata[15:0];
            err1_q <= (clear_q ? ERR_RST : err1_q) | err1_set;
            err2_q <= (clear_q ? ERR_RST : err2_q) | err2_set;
            if (attn_event) attn_q <= 1'h1;
            else if (clear_q || (wr_stat && pwdata[STAT_ATTN])) attn_q <= 1'h0;
        end
    end
    assign attention_flag = attn_q;
    assign search_enable  = ctrl_q[CTRL_SEARCH];
    assign on_latch       = ctrl_q[CTRL_ON];

    // checks
    start_gate_a: assert property ($fell(seq_out_q.busy_oe_n) |-> $past(start_ok, 2))
        else $error("start began without all start conditions");
    busy_hold_a: assert property ((state_q == st_off && !sq_f.start_busy_line)
                                  |=> state_q != st_start)
        else $error("start attempted while busy line low");
    start_drive_a: assert property (state_q == st_start |=> (!seq_out_q.power_pick
        && !seq_out_q.power_hold && !seq_out_q.busy_oe_n && !seq_out_q.busy_out))
        else $error("start outputs wrong");
    ready_grant_a: assert property ((state_q == st_start && sq_f.unit_ready
        && !sq_f.drive_fault && sq_f.start_req && sq_f.dc_ok)
        |=> ##1 (!seq_out_q.grant_out_n && seq_out_q.busy_oe_n))
        else $error("ready did not grant and release busy");
    fail_grant_a: assert property ((state_q == st_fail && sq_f.drive_fault)
        |=> (state_q == st_fail) ##1 !seq_out_q.grant_out_n)
        else $error("failed start must keep granting");
    stop_power_a: assert property ((state_q == st_run && !sq_f.start_req)
        |=> ##1 (seq_out_q.power_pick && seq_out_q.power_hold))
        else $error("stop did not assert pick and hold");
    pass_through_a: assert property (state_q == st_off
        |=> seq_out_q.grant_out_n == $past(sq_f.grant_in_n))
        else $error("stopped drive did not pass permit");
    init_clear_a: assert property (init_rise |=> clear_q ##1 (!attn_q || $past(attn_event)))
        else $error("initialize did not clear");
    clear_regs_a: assert property (clear_q |=> (!maint_q[0] && ctrl_q[CTRL_ON]
        && !ctrl_q[CTRL_SEARCH] && ecc_q == ECC_RST))
        else $error("clear pulse left state behind");
    plug_gate_a: assert property (!plug_f.present |=> !hs_q && rsel_q == 5'h00)
        else $error("match without unit plug");
    port_b_off_a: assert property ((!ctrl_q[CTRL_DUAL] && match_a && pa_f.demand)
        |=> hs_q)
        else $error("first port not used when second port is off");

    // clear sources and effects, routing, permit, power and busy release; each samples one edge later
    pok_clear_a: assert property ((pok_rise || drv_clr_cmd) |=> clear_q)
        else $error("power good or drive clear made no clear pulse");
    err_clear_a: assert property (clear_q |=> (err1_q == $past(err1_set)
        && err2_q == $past(err2_set)))
        else $error("clear pulse left error bits behind");
    route_sel_a: assert property ((match && sel_bus.demand) |=> (hs_q
        && rsel_q == $past(sel_bus.reg_sel)))
        else $error("match did not start handshake with routed select");
    addr_diff_a: assert property ((!port_b_mode
        && pa_f.drive_select_lines != plug_f.unit_plug_address) |=> !hs_q)
        else $error("first port handshake without address match");
    port_b_sel_a: assert property ((port_b_mode && !match_b)
        |=> (!hs_q && rsel_q == 5'h00))
        else $error("second port mode used the wrong comparator");
    run_grant_a: assert property (state_q == st_run |=> !seq_out_q.grant_out_n)
        else $error("running drive withheld permit");
    busy_free_a: assert property (state_q != st_start |=> seq_out_q.busy_oe_n)
        else $error("busy line pulled outside a start");
    off_power_a: assert property (state_q == st_off
        |=> (seq_out_q.power_pick && seq_out_q.power_hold))
        else $error("stopped drive not held off");

    start_run_c: cover property (state_q == st_start ##[1:20] state_q == st_run);
    fail_retry_c: cover property (state_q == st_fail ##[1:20] state_q == st_start);
    select_b_c: cover property (port_b_mode && hs_q);
    clear_c: cover property (init_rise ##1 clear_q);
    stop_c: cover property (state_q == st_run ##1 state_q == st_off);

endmodule

`default_nettype wire

// >>> testbench/drive_model.sv
// behavioural drive electronics and neighbour on the start-busy wire
`timescale 1ns/1ps
`default_nettype none
module drive_model (
    input  wire logic                       pclk,        // system clock
    input  wire logic                       presetn,     // async reset, low
    input  wire disk_adapter_pkg::seq_out_t seq_out,     // adapter power outputs
    input  wire logic                       other_pull,  // neighbour is starting
    input  wire logic                       fail_mode,   // motor will not come up
    input  wire logic [7:0]                 spin_len,    // spin-up time in cycles
    output logic                            unit_ready,  // spun up, heads loaded
    output logic                            drive_fault, // start failed
    output logic                            busy_wire    // start-busy wire level
);
    import disk_adapter_pkg::*;
    logic [7:0] spin_q;
    logic       live;
    // energized only with both pick and hold at ground
    assign live = !seq_out.power_pick && !seq_out.power_hold;
    // pulled-up wire, low while any party pulls it
    assign busy_wire = !(other_pull || !seq_out.busy_oe_n);
    assign unit_ready = live && spin_q == spin_len && !fail_mode;
    // spin count; a failed start latches the fault until repaired
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            spin_q      <= 8'h00;
            drive_fault <= 1'h0;
        end else begin
            spin_q      <= !live ? 8'h00 : (spin_q == spin_len ? spin_q : spin_q + 8'h01);
            drive_fault <= fail_mode && (drive_fault || (live && spin_q == spin_len));
        end
    end
endmodule
`default_nettype wire

// >>> testbench/test_disk_adapter_ctrl.sv
// self-checking bench for the disk adapter control block
`timescale 1ns/1ps
`default_nettype none
module test_disk_adapter_ctrl;
    import disk_adapter_pkg::*;
    logic        pclk = 1'h0;
    logic        presetn = 1'h0;
    logic [7:0]  paddr = 8'h00;
    logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr;
    logic [31:0] pwdata = 32'h0, prdata, obs, exp_q[$];
    port_bus_t   port_a = '0, port_b = '0;
    unit_plug_t  unit_plug = 4'hD;
    logic        attn_event = 1'h0, start_req = 1'h0, dc_ok = 1'h0, grant_in_n = 1'h0;
    logic        other_pull = 1'h0, fail_mode = 1'h0, snap = 1'h0;
    logic [7:0]  spin_len = 8'h20;
    logic [15:0] err1_set = 16'h0000, err2_set = 16'h0000;
    logic        unit_ready, drive_fault, busy_wire, hs, attn, srch, onl, clr, fclr, clr_prev = 1'h0;
    logic [4:0]  rsel;
    seq_out_t    seq_out;
    seq_in_t     seq_in;
    int          err_count = 0, checks = 0, clr_cnt = 0;
    assign seq_in = {start_req, dc_ok, grant_in_n, busy_wire, unit_ready, drive_fault};
    assign obs = {18'h0, seq_out, hs, rsel, attn, srch, onl};
    always #50 pclk = ~pclk;
    disk_adapter_ctrl DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .port_a(port_a), .port_b(port_b),
        .seq_in(seq_in), .unit_plug(unit_plug), .attn_event(attn_event),
        .err1_set(err1_set), .err2_set(err2_set), .seq_out(seq_out),
        .adapter_clear_pulse(clr), .drive_fault_clear(fclr), .handshake_start(hs),
        .reg_select_out(rsel), .attention_flag(attn), .search_enable(srch), .on_latch(onl));
    drive_model MODEL (.pclk(pclk), .presetn(presetn), .seq_out(seq_out),
        .other_pull(other_pull), .fail_mode(fail_mode), .spin_len(spin_len),
        .unit_ready(unit_ready), .drive_fault(drive_fault), .busy_wire(busy_wire));
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks++;
        if (seen !== want) begin
            err_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic tally_and_finish();
        if (err_count == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // one apb transfer, held until pready is seen high
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        {psel, penable, paddr, pwrite, pwdata} <= {1'h1, 1'h0, a, w, d};
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1) begin
            if (++n > 40) begin
                err_count++;
                tally_and_finish();
            end
            @(posedge pclk);
        end
        {psel, penable} <= 2'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] want);
        exp_q.push_back(want);
        apb(a, 1'h0, 32'h0);
    endtask
    // wait bounded for the pin pattern, then have the monitor confirm it
    task automatic pins(input logic [4:0] s, input logic h, input logic [4:0] r,
                        input logic [2:0] f);
        logic [31:0] want;
        want = {18'h0, s, h, r, f};
        for (int i = 0; i < 80 && obs !== want; i++) @(posedge pclk);
        if (obs !== want) begin
            check(obs, want);
            tally_and_finish();
        end
        exp_q.push_back(want);
        @(posedge pclk);
        snap <= 1'h1;
        @(posedge pclk);
        snap <= 1'h0;
    endtask
    // oldest note first; falling edge so registered outputs have settled
    always @(negedge pclk) begin
        if (psel && penable && pready && !pwrite) check(prdata | {pslverr, 31'h0}, exp_q.pop_front());
        if (snap) check(obs, exp_q.pop_front());
        if (clr || fclr) check({clr, fclr, clr_prev}, 32'h6);
        clr_cnt += clr;
        clr_prev = clr;
    end
    initial begin
        void'($urandom(32'h57791018));
        repeat (16) @(posedge pclk);
        presetn <= 1'h1;
        dc_ok <= 1'h1;
        pins(5'h19, 1'h0, 5'h00, 3'h1);
        rd(OFF_CTRL, 32'h10);
        for (int i = 0; i < 4; i++) rd(OFF_MAINT + 8'(4 * i), 32'h0);
        rd(8'h40, 32'h8000_0000); // unmapped place answers with slave error
        // neighbour holds the busy wire, then the incoming permit is high
        {other_pull, start_req} <= 2'h3;
        repeat (15) @(posedge pclk);
        pins(5'h19, 1'h0, 5'h00, 3'h1);
        {other_pull, grant_in_n} <= 2'h1;
        repeat (15) @(posedge pclk);
        pins(5'h1D, 1'h0, 5'h00, 3'h1);
        grant_in_n <= 1'h0;
        pins(5'h04, 1'h0, 5'h00, 3'h1);
        pins(5'h01, 1'h0, 5'h00, 3'h1);
        rd(OFF_STATUS, 32'h1C);
        start_req <= 1'h0;
        pins(5'h19, 1'h0, 5'h00, 3'h1);
        grant_in_n <= 1'h1;
        pins(5'h1D, 1'h0, 5'h00, 3'h1);
        {grant_in_n, start_req, spin_len} <= {1'h0, 1'h1, 8'h02};
        pins(5'h04, 1'h0, 5'h00, 3'h1);
        pins(5'h01, 1'h0, 5'h00, 3'h1);
        // clear sources: port a, port b unfitted, port b fitted, drive clear
        for (int s = 0; s < 4; s++) begin
            int n0;
            apb(OFF_CTRL, 1'h1, s == 2 ? 32'h0C : 32'h08);
            apb(OFF_MAINT, 1'h1, 32'hFFFF);
            apb(OFF_ECC, 1'h1, 32'h1234);
            {attn_event, err1_set, err2_set} <= {1'h1, 16'h0101, 16'h8002};
            @(posedge pclk);
            {attn_event, err1_set, err2_set} <= 33'h0;
            pins(5'h01, 1'h0, 5'h00, 3'h6);
            n0 = clr_cnt;
            if (s == 3) apb(OFF_CTRL, 1'h1, 32'h09);
            else if (s == 0) port_a.init <= 1'h1;
            else port_b.init <= 1'h1;
            repeat (8) @(posedge pclk);
            {port_a.init, port_b.init} <= 2'h0;
            pins(5'h01, 1'h0, 5'h00, s == 1 ? 3'h6 : 3'h1);
            check(clr_cnt - n0, s == 1 ? 32'h0 : 32'h1);
            rd(OFF_MAINT, s == 1 ? 32'hFFFF : 32'hFFFE);
            rd(OFF_ECC, s == 1 ? 32'h1234 : 32'h0);
            rd(OFF_ERR1, s == 1 ? 32'h0101 : 32'h0);
            rd(OFF_ERR2, s == 1 ? 32'h8002 : 32'h0);
            if (s == 1) apb(OFF_STATUS, 1'h1, 32'h01);
            if (s == 1) pins(5'h01, 1'h0, 5'h00, 3'h2);
        end
        // random selects, addresses, plug and port choice
        for (int k = 0; k < 24; k++) begin
            logic [31:0] r;
            port_bus_t   pa, pb, sl;
            unit_plug_t  pl;
            r = $urandom();
            pa = {r[0], 1'h0, r[22] ? r[21:19] : r[3:1], r[8:4]};
            pb = {r[9], 1'h0, r[23] ? r[21:19] : r[12:10], r[17:13]};
            pl = {r[24] | r[25], r[21:19]};
            sl = (r[26] & r[27]) ? pb : pa;
            apb(OFF_CTRL, 1'h1, {27'h0, 2'h2, r[27], r[26], 1'h0});
            {port_a, port_b, unit_plug} <= {pa, pb, pl};
            repeat (10) @(posedge pclk);
            if (pl.present && sl.drive_select_lines == pl.unit_plug_address) pins(5'h01, sl.demand, sl.reg_sel, 3'h1);
            else pins(5'h01, 1'h0, 5'h00, 3'h1);
        end
        // a start that fails still passes the permit, then retries
        {port_a, port_b, unit_plug, start_req} <= {20'h0, 4'hD, 1'h0};
        apb(OFF_CTRL, 1'h1, 32'h10);
        pins(5'h19, 1'h0, 5'h00, 3'h1);
        {fail_mode, start_req} <= 2'h3;
        pins(5'h04, 1'h0, 5'h00, 3'h1);
        pins(5'h19, 1'h0, 5'h00, 3'h1);
        rd(OFF_STATUS, 32'h36);
        fail_mode <= 1'h0;
        pins(5'h01, 1'h0, 5'h00, 3'h1);
        tally_and_finish();
    end
endmodule
`default_nettype wire
